// ===== test/amp_host_model.sv
// Host side of the shared pin: strap resistor and fault monitor
`timescale 1ns/1ns
module amp_host_model (
    // Strap choice
    input wire logic strap_high,
    // Pin as driven by the block
    input wire logic adr_fault_out,
    input wire logic adr_fault_oe_n,
    // Resolved pin and host view
    output logic pin_level,
    output logic fault_seen
);
    // Resistor sets the level whenever the block lets go
    assign pin_level = adr_fault_oe_n ? strap_high : adr_fault_out;
    // A low line is read as a fault report
    assign fault_seen = !pin_level;
endmodule

// ===== test/amp_prot_props.sv
// Port-level checks for the protection block
`timescale 1ns/1ns
module amp_prot_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pready,
    // Detectors and pin
    input wire logic over_temp,
    input wire logic undervoltage_protection,
    input wire logic adr_fault_out,
    input wire logic adr_fault_oe_n,
    input wire logic high_impedance_state,
    input wire logic [6:0] slave_addr
);
    // Error clear on the bus; a few lags cover the answer delay
    wire logic clr_wr = psel && pwrite && paddr == 32'h8;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_pulse:
        assert property (pready |=> !pready)
        else $error("ready longer than a cycle");
    a_access_answer:
        assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access");
    a_addr_legal:
        assert property (slave_addr inside {7'h1A, 7'h1B})
        else $error("illegal address");
    a_addr_frozen:
        assert property (!adr_fault_oe_n && !$past(adr_fault_oe_n)
            |=> $stable(slave_addr))
        else $error("address moved after strap");
    a_temp_hiz:
        assert property (over_temp [*5] |-> high_impedance_state)
        else $error("no high impedance on over-temperature");
    a_uv_hiz:
        assert property (undervoltage_protection [*5]
            |-> high_impedance_state)
        else $error("no high impedance on undervoltage");
    a_temp_pin:
        assert property (over_temp [*6] ##0 !adr_fault_oe_n
            |-> !adr_fault_out)
        else $error("fault pin not low");
    a_pin_release:
        assert property ($rose(adr_fault_out) |-> $past(clr_wr, 2)
            || $past(clr_wr, 3) || $past(clr_wr, 4))
        else $error("fault pin released without clear");
endmodule
bind amp_protection_fault_control amp_prot_props amp_prot_props_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
    .over_temp, .undervoltage_protection, .adr_fault_out,
    .adr_fault_oe_n, .high_impedance_state, .slave_addr);

// ===== test/tb.sv
// Bench for the protection and fault block
`timescale 1ns/1ns
module tb;
    import amp_prot_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, strap_high;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic pready, pslverr, berr, pin_level, fault_seen, irq;
    logic power_stage_supply_good, analog_supply_good, circuits_active;
    logic adr_fault_out, adr_fault_oe_n, high_impedance_state;
    logic [6:0] slave_addr;
    fault_in_t flt;
    int miscompares, cmp_count;
    amp_protection_fault_control amp_protection_fault_control_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .power_stage_supply_good,
        .analog_supply_good, .overcurrent_detect(flt.overcurrent_detect),
        .over_temp(flt.over_temp), .over_voltage(flt.over_voltage),
        .undervoltage_protection(flt.undervoltage_protection),
        .adr_fault_in(pin_level), .adr_fault_out, .adr_fault_oe_n,
        .high_impedance_state, .circuits_active, .slave_addr, .irq);
    amp_host_model amp_host_model_i (.strap_high, .adr_fault_out,
        .adr_fault_oe_n, .pin_level, .fault_seen);
    // Clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic final_report;
        $display("Compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // One transfer; one idle edge after it keeps drivers apart
    task automatic apb(input logic w, input logic [31:0] a, d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        wt(1);
        penable <= 1'b1;
        do begin
            wt(1);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            final_report;
        end
        rd = prdata;
        berr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        wt(1);
    endtask
    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d);
    endtask
    task automatic rdr(input logic [31:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_hiz(input logic v);
        int k;
        k = 0;
        while (high_impedance_state !== v && k < 20) begin
            wt(1);
            k++;
        end
        if (k >= 20) begin
            miscompares++;
            final_report;
        end
        chk(high_impedance_state, v);
    endtask
    task automatic rst(input logic s, input logic g);
        presetn <= 1'b0;
        strap_high <= s;
        power_stage_supply_good <= g;
        wt(3);
        presetn <= 1'b1;
        wt(16);
    endtask
    // Low supply holds the stage off; strap picks each address
    task automatic t_por;
        rst(1'b0, 1'b0);
        chk(circuits_active, 1'b0);
        chk(high_impedance_state, 1'b1);
        chk(slave_addr, 7'h1A);
        power_stage_supply_good <= 1'b1;
        wt(8);
        chk(circuits_active, 1'b1);
        wr(32'h8, 32'h0);
        wt(4);
        chk(high_impedance_state, 1'b0);
        rst(1'b1, 1'b1);
        chk(slave_addr, 7'h1B);
        strap_high <= 1'b0;
        wt(4);
        chk(slave_addr, 7'h1B);
    endtask
    // Refusals, reset values and the pin enable
    task automatic t_bus;
        rdr(32'h0);
        chk(rd, 32'h1);
        rdr(32'h70);
        chk(rd, 32'h100);
        rdr(32'h40);
        chk(berr, 1'b1);
        wr(32'h80, 32'h3);
        chk(berr, 1'b1);
        wr(32'h0, 32'h0);
        wt(3);
        chk(adr_fault_oe_n, 1'b1);
        wr(32'h0, 32'h1);
        wt(3);
        chk(adr_fault_oe_n, 1'b0);
    endtask
    // Every cause pulls the pin low; clear while live does not stick
    task automatic t_causes;
        wr(32'h70, 32'h10);
        for (int i = 0; i < 4; i++) begin
            flt <= fault_in_t'(4'b1000 >> i);
            wt(10);
            chk(fault_seen, 1'b1);
            chk(high_impedance_state, i != 2);
            wr(32'h8, 32'h0);
            rdr(32'h8);
            chk(rd & (32'h1 << i), 32'h1 << i);
            flt <= '0;
            wt(30);
            chk(adr_fault_out, 1'b0);
            chk(high_impedance_state, 1'b0);
            wr(32'h8, 32'h0);
            wt(4);
            chk(adr_fault_out, 1'b1);
        end
    endtask
    // Lasting overcurrent: off for the programmed time, then trips again
    task automatic t_retry;
        int k;
        k = 0;
        flt <= fault_in_t'(4'b1000);
        wait_hiz(1'b1);
        while (high_impedance_state === 1'b1 && k < 60) begin
            wt(1);
            k++;
        end
        if (k >= 60) begin
            miscompares++;
            final_report;
        end
        chk(k >= 16 && k <= 20, 1'b1);
        wait_hiz(1'b1);
        flt <= '0;
        wt(40);
        chk(high_impedance_state, 1'b0);
    endtask
    // Interrupt raised, masked, then cleared
    task automatic t_irq;
        // Earlier scenarios leave stale status; start from a clean one
        wr(32'h84, 32'hF);
        wr(32'h88, 32'h2);
        wt(2);
        chk(irq, 1'b0);
        flt <= fault_in_t'(4'b0100);
        wt(10);
        chk(irq, 1'b1);
        wr(32'h88, 32'h0);
        wt(2);
        chk(irq, 1'b0);
        flt <= '0;
        wt(6);
        wr(32'h84, 32'hF);
        rdr(32'h80);
        chk(rd, 32'h0);
        wr(32'h8, 32'h0);
    endtask
    // Analog supply dip: stage off and fault, back on when good
    task automatic t_analog_supply;
        analog_supply_good <= 1'b0;
        wt(6);
        chk(circuits_active, 1'b0);
        chk(high_impedance_state, 1'b1);
        chk(fault_seen, 1'b1);
        analog_supply_good <= 1'b1;
        wt(6);
        chk(circuits_active, 1'b1);
        chk(high_impedance_state, 1'b0);
        wr(32'h8, 32'h0);
        wt(4);
        chk(adr_fault_out, 1'b1);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        strap_high = 1'b0;
        power_stage_supply_good = 1'b1;
        analog_supply_good = 1'b1;
        flt = '0;
        miscompares = 0;
        cmp_count = 0;
        t_por;
        t_bus;
        t_causes;
        t_retry;
        t_irq;
        t_analog_supply;
        final_report;
    end
endmodule

// ===== verilog/amp_prot_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AMP_PROT_MAP_SVH
`define AMP_PROT_MAP_SVH
`define ADDR_STRAP_HIGH 7'h1B
`define ADDR_STRAP_LOW 7'h1A
`define REG_ERR_STATUS 32'h0000_0008
`define REG_OC_RETRY 32'h0000_0070
`define REG_CTRL 32'h0000_0000
`define REG_IRQ_STATUS 32'h0000_0080
`define REG_IRQ_CLEAR 32'h0000_0084
`define REG_IRQ_ENABLE 32'h0000_0088
`define REG_STATE 32'h0000_008C
`define ERR_OC_BIT 0
`define ERR_OT_BIT 1
`define ERR_OV_BIT 2
`define ERR_UV_BIT 3
`define CTRL_FAULT_EN_BIT 0
`define OC_RETRY_RESET 16'h0100
`define OC_PERSIST_CYCLES 8'h04
`define STRAP_SETTLE_CYCLES 4'h8
`endif

// ===== verilog/amp_prot_pkg.sv
// Types shared by the protection block
package amp_prot_pkg;
    typedef enum logic [1:0] {
        ST_POR,
        ST_RUN,
        ST_OC_WAIT
    } prot_state_t;

    typedef struct packed {
        logic overcurrent_detect;
        logic over_temp;
        logic over_voltage;
        logic undervoltage_protection;
    } fault_in_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// ===== verilog/amp_protection_fault_control.sv
// Protection, strap address and fault pin control with APB registers
`timescale 1ns/1ns
`include "amp_prot_map.svh"
module amp_protection_fault_control
    import amp_prot_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply good and detector pins (asynchronous)
    input wire logic power_stage_supply_good,
    input wire logic analog_supply_good,
    input wire logic overcurrent_detect,
    input wire logic over_temp,
    input wire logic over_voltage,
    input wire logic undervoltage_protection,
    // Shared address/fault pin
    input wire logic adr_fault_in,
    output logic adr_fault_out,
    output logic adr_fault_oe_n,
    // Power stage and status
    output logic high_impedance_state,
    output logic circuits_active,
    output logic [6:0] slave_addr,
    output logic irq
);
    // Pins pass two flops before use
    logic [6:0] pin_s;
    sync_2ff #(.W(7)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({power_stage_supply_good, analog_supply_good,
              overcurrent_detect, over_temp, over_voltage,
              undervoltage_protection, adr_fault_in}),
        .dout(pin_s)
    );
    logic power_stage_supply_ok;
    logic analog_supply_ok;
    logic strap_s;
    fault_in_t flt;
    assign power_stage_supply_ok = pin_s[6];
    assign analog_supply_ok = pin_s[5];
    assign flt = fault_in_t'(pin_s[4:1]);
    assign strap_s = pin_s[0];

    // Control state
    prot_state_t state_q, state_d;
    logic [15:0] retry_q, retry_d;
    logic [15:0] cnt_q, cnt_d;
    logic [7:0] ocp_q, ocp_d;
    logic [3:0] settle_q, settle_d;
    logic [6:0] addr_q, addr_d;
    logic strap_done_q, strap_done_d;
    logic fault_en_q, fault_en_d;
    logic [3:0] irq_en_q, irq_en_d;
    logic hiz_q, hiz_d;
    logic act_q, act_d;
    logic pin_out_q, pin_out_d;
    logic pin_oe_n_q, pin_oe_n_d;
    logic irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;

    // Sticky error and interrupt flags
    logic [3:0] err_set;
    logic [3:0] err_clr;
    logic [3:0] err_flags;
    logic [3:0] irq_clr;
    logic [3:0] irq_flags;
    logic supplies_ok;
    logic oc_latched;

    assign supplies_ok = power_stage_supply_ok & analog_supply_ok;
    assign oc_latched = (ocp_q == `OC_PERSIST_CYCLES);
    // Live conditions keep re-setting their bits
    always_comb begin
        err_set = 4'h0;
        if (strap_done_q) begin
            err_set[`ERR_OC_BIT] = state_q == ST_OC_WAIT;
            err_set[`ERR_OT_BIT] = flt.over_temp;
            err_set[`ERR_OV_BIT] = flt.over_voltage;
            err_set[`ERR_UV_BIT] = flt.undervoltage_protection
                | ~supplies_ok;
        end
    end

    sticky_bits #(.W(4)) u_err (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(err_set),
        .clr_i(err_clr),
        .flag_o(err_flags)
    );
    sticky_bits #(.W(4)) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(err_set),
        .clr_i(irq_clr),
        .flag_o(irq_flags)
    );

    // APB access phase takes two cycles (one wait state); ready lasts one cycle
    logic acc;
    logic wdone;
    assign acc = psel & penable & ~ready_q;
    // Writes land at the edge that sees pready high, never earlier
    assign wdone = psel & penable & pwrite & ready_q & ~err_q;
    always_comb begin
        fault_en_d = fault_en_q;
        irq_en_d = irq_en_q;
        retry_d = retry_q;
        err_clr = 4'h0;
        irq_clr = 4'h0;
        rdata_d = 32'h0000_0000;
        ready_d = acc;
        err_d = 1'b0;
        if (wdone) begin
            unique case (paddr)
                `REG_CTRL: fault_en_d = pwdata[`CTRL_FAULT_EN_BIT];
                `REG_ERR_STATUS: err_clr = ~pwdata[3:0];
                `REG_OC_RETRY: retry_d = pwdata[15:0];
                `REG_IRQ_CLEAR: irq_clr = pwdata[3:0];
                `REG_IRQ_ENABLE: irq_en_d = pwdata[3:0];
                default: ;
            endcase
        end
        if (acc && pwrite) begin
            // Read-only and unmapped offsets refuse the write
            unique case (paddr)
                `REG_CTRL, `REG_ERR_STATUS, `REG_OC_RETRY,
                `REG_IRQ_CLEAR, `REG_IRQ_ENABLE: err_d = 1'b0;
                default: err_d = 1'b1;
            endcase
        end else if (acc) begin
            unique case (paddr)
                `REG_CTRL: rdata_d = {31'h0, fault_en_q};
                `REG_ERR_STATUS: rdata_d = {28'h0, err_flags};
                `REG_OC_RETRY: rdata_d = {16'h0, retry_q};
                `REG_IRQ_STATUS: rdata_d = {28'h0, irq_flags};
                `REG_IRQ_ENABLE: rdata_d = {28'h0, irq_en_q};
                `REG_STATE: rdata_d = {16'h0, 1'b0, addr_q,
                    4'h0, strap_done_q, act_q, hiz_q, pin_out_q};
                `REG_IRQ_CLEAR: rdata_d = 32'h0000_0000;
                default: err_d = 1'b1;
            endcase
        end
    end

    // Strap sampling during power-up, then frozen
    always_comb begin
        settle_d = settle_q;
        addr_d = addr_q;
        strap_done_d = strap_done_q;
        if (!strap_done_q) begin
            if (settle_q != `STRAP_SETTLE_CYCLES) begin
                settle_d = settle_q + 4'h1;
            end else begin
                addr_d = strap_s ? `ADDR_STRAP_HIGH
                    : `ADDR_STRAP_LOW;
                strap_done_d = 1'b1;
            end
        end
    end

    // Protection sequencer; every cause but over_voltage idles the whole bridge
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ocp_d = 8'h00;
        act_d = act_q;
        unique case (state_q)
            ST_POR: begin
                act_d = 1'b0;
                if (strap_done_q && supplies_ok) begin
                    state_d = ST_RUN;
                    act_d = 1'b1;
                end
            end
            ST_RUN: begin
                if (!supplies_ok) begin
                    state_d = ST_POR;
                    act_d = 1'b0;
                end else if (flt.overcurrent_detect) begin
                    ocp_d = oc_latched ? ocp_q : ocp_q + 8'h01;
                    if (oc_latched) begin
                        state_d = ST_OC_WAIT;
                        cnt_d = 16'h0000;
                        ocp_d = 8'h00;
                    end
                end
            end
            ST_OC_WAIT: begin
                cnt_d = cnt_q + 16'h0001;
                if (!supplies_ok) begin
                    state_d = ST_POR;
                    act_d = 1'b0;
                end else if (cnt_q >= retry_q) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    // Outputs: all four half-bridges share one enable
    always_comb begin
        hiz_d = (state_d != ST_RUN)
            | flt.over_temp
            | flt.undervoltage_protection;
        // Pin stays an input until the strap is caught
        pin_oe_n_d = ~(strap_done_q & fault_en_q);
        pin_out_d = ~(|err_flags);
        irq_d = |(irq_flags & irq_en_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_POR;
            retry_q <= `OC_RETRY_RESET;
            cnt_q <= 16'h0000;
            ocp_q <= 8'h00;
            settle_q <= 4'h0;
            addr_q <= `ADDR_STRAP_LOW;
            strap_done_q <= 1'b0;
            fault_en_q <= 1'b1;
            irq_en_q <= 4'h0;
            hiz_q <= 1'b1;
            act_q <= 1'b0;
            pin_out_q <= 1'b1;
            pin_oe_n_q <= 1'b1;
            irq_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            retry_q <= retry_d;
            cnt_q <= cnt_d;
            ocp_q <= ocp_d;
            settle_q <= settle_d;
            addr_q <= addr_d;
            strap_done_q <= strap_done_d;
            fault_en_q <= fault_en_d;
            irq_en_q <= irq_en_d;
            hiz_q <= hiz_d;
            act_q <= act_d;
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign adr_fault_out = pin_out_q;
    assign adr_fault_oe_n = pin_oe_n_q;
    assign high_impedance_state = hiz_q;
    assign circuits_active = act_q;
    assign slave_addr = addr_q;
    assign irq = irq_q;
endmodule

// ===== verilog/sticky_bits.sv
// Sticky flags, set beats clear, one generate block per bit
`timescale 1ns/1ns
`include "amp_prot_map.svh"
module sticky_bits #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events and clear
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flag_o
);
    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    // Set has priority so a live event survives a clear
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                flag_d[i] = set_i[i] | (flag_q[i] & ~clr_i[i]);
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule

// ===== verilog/sync_2ff.sv
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
module sync_2ff #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    // First stage feeds only the second
    always_comb begin
        meta_d = din;
        out_d = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            out_q <= '0;
        end else begin
            meta_q <= meta_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule
